// >>> adc_link_cfg.svh
// Constants for the converter serial read-out link
`ifndef ADC_LINK_CFG_SVH
`define ADC_LINK_CFG_SVH

// Command byte field positions
`define CMD_START_POS      7
`define CMD_UNIPOLAR_POS   3
`define CMD_PD_HIGH_POS    1
`define CMD_PD_LOW_POS     0

// Frame shape in serial clock periods
`define CMD_BITS           8
`define RESULT_BITS        14
`define FRAME_BITS         16
`define BYTE_BITS          8

// Timing figures as printed, plus the system clock rate
`define CLK_KHZ            25000
`define SCLK_MAX_KHZ       2100
`define WAKE_TIME_US       2000

// Idle system clock cycles between the two byte reads
`define BYTE_GAP_CYCLES    4

`endif

// >>> adc_link_pkg.sv
// Types for the host end and the converter end of the serial link
`default_nettype none

package adc_link_pkg;

    // Device power state, coded as the two power-mode bits
    typedef enum logic [1:0] {
        PS_FULL_DOWN = 2'b00,
        PS_FAST_DOWN = 2'b01,
        PS_ACTIVE    = 2'b10
    } power_state_type;

    // Device frame phase on the link clock
    typedef enum logic [1:0] {
        DP_WAIT = 2'b00,
        DP_CMD  = 2'b01,
        DP_DATA = 2'b10
    } dev_phase_type;

    // Host transaction state
    typedef enum logic [1:0] {
        HS_IDLE = 2'b00,
        HS_XFER = 2'b01,
        HS_GAP  = 2'b10,
        HS_DONE = 2'b11
    } host_state_type;

endpackage

`default_nettype wire

// >>> adc_link_if.sv
// Four-wire serial link between host and converter
`timescale 1ns/100ps
`default_nettype none

interface adc_link_if;
    logic sclk;      // Serial clock, host driven
    logic cs_n;      // Chip select, active low
    logic cmd_line;  // Host to device command bits
    logic res_line;  // Device result bit
    logic res_oe;    // Device drives result line
    wire  res_level; // Resolved result line level

    // Undriven result line reads low
    assign res_level = res_oe ? res_line : 1'b0;

    modport host (
        output sclk,
        output cs_n,
        output cmd_line,
        input  res_level
    );

    modport dev (
        input  sclk,
        input  cs_n,
        input  cmd_line,
        output res_line,
        output res_oe
    );
endinterface

`default_nettype wire

// >>> adc_word_buffer.sv
// Small FIFO holding result words ahead of the host user
`timescale 1ns/100ps
`default_nettype none

module adc_word_buffer #(
    parameter int WIDTH = 15,
    parameter int DEPTH = 2
) (
    input  wire logic             clk,       // System clock
    input  wire logic             arst_n,    // Async reset, low
    input  wire logic [WIDTH-1:0] in_data,   // Word to store
    input  wire logic             in_valid,  // Store request
    output logic                  in_ready,  // Space left
    output logic      [WIDTH-1:0] out_data,  // Oldest word
    output logic                  out_valid, // Word present
    input  wire logic             out_ready  // Reader takes word
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [AW:0]   FULL_COUNT = (AW + 1)'(DEPTH);
    localparam logic [AW-1:0] LAST_SLOT  = AW'(DEPTH - 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    logic [AW-1:0]    next_wr_ptr;
    logic [AW-1:0]    next_rd_ptr;
    logic [AW:0]      next_count;
    logic             do_wr;
    logic             do_rd;

    // Honest flags; the writer stalls on a full buffer
    assign in_ready  = count != FULL_COUNT;
    assign out_valid = count != '0;
    assign out_data  = mem[rd_ptr];
    assign do_wr     = in_valid && in_ready;
    assign do_rd     = out_valid && out_ready;

    // Pointer wrap and occupancy
    always_comb begin
        next_wr_ptr = wr_ptr;
        next_rd_ptr = rd_ptr;
        next_count  = count;
        if (do_wr) begin
            next_wr_ptr = (wr_ptr == LAST_SLOT) ? '0 : wr_ptr + 1'b1;
        end
        if (do_rd) begin
            next_rd_ptr = (rd_ptr == LAST_SLOT) ? '0 : rd_ptr + 1'b1;
        end
        if (do_wr && !do_rd) begin
            next_count = count + 1'b1;
        end else if (do_rd && !do_wr) begin
            next_count = count - 1'b1;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count  <= next_count;
        end
    end

    // Storage carries no reset; out_valid guards it
    always_ff @(posedge clk) begin
        if (do_wr) begin
            mem[wr_ptr] <= in_data;
        end
    end
endmodule

`default_nettype wire

// >>> adc_serial_device.sv
// Converter end of the link, clocked by the serial clock
`timescale 1ns/100ps
`default_nettype none
`include "adc_link_cfg.svh"

module adc_serial_device (
    adc_link_if.dev                     link,          // Serial pins
    input  wire logic                   arst_n,        // Async reset, low
    input  wire logic [13:0]            sample_code,   // Sample, offset bin
    input  wire logic                   ext_ref,       // External reference
    output adc_link_pkg::power_state_type power_state, // Power state
    output logic                        ready_to_conv  // No wake wait due
);
    import adc_link_pkg::*;

    localparam logic [4:0] CMD_LAST   = 5'(`CMD_BITS - 1);
    localparam logic [4:0] CONV_LAST  = 5'(`RESULT_BITS - 1);
    localparam logic [4:0] FRAME_LAST = 5'(`FRAME_BITS - 1);

    dev_phase_type   phase;
    dev_phase_type   next_phase;
    logic [4:0]      cnt;
    logic [4:0]      next_cnt;
    logic [6:0]      cmd_sr;
    logic [6:0]      next_cmd_sr;
    logic [15:0]     out_sr;
    logic [15:0]     next_out_sr;
    logic            pd_pending;
    logic            next_pd_pending;
    power_state_type pd_choice;
    power_state_type next_pd_choice;
    power_state_type next_power;
    logic            next_ready;
    logic            next_dout;
    logic [7:0]      cmd_full;
    logic [13:0]     code;
    logic [13:0]     sample_meta;
    logic [13:0]     sample_sync;
    logic            ext_meta;
    logic            ext_sync;
    logic            frame_rst_n;

    // Raising chip select aborts the frame and drops the result
    assign frame_rst_n   = arst_n & ~link.cs_n;
    assign link.res_oe   = ~link.cs_n;
    assign cmd_full      = {cmd_sr, link.cmd_line};

    // Bipolar results flip the sign bit of the offset code
    assign code = cmd_full[`CMD_UNIPOLAR_POS] ? sample_sync
                : {~sample_sync[13], sample_sync[12:0]};

    // Sample and strap cross into the link clock; stale while idle
    always_ff @(posedge link.sclk or negedge arst_n) begin
        if (!arst_n) begin
            sample_meta <= 14'h0000;
            sample_sync <= 14'h0000;
            ext_meta    <= 1'b0;
            ext_sync    <= 1'b0;
        end else begin
            sample_meta <= sample_code;
            sample_sync <= sample_meta;
            ext_meta    <= ext_ref;
            ext_sync    <= ext_meta;
        end
    end

    // Frame sequencing on rising serial clock edges
    always_comb begin
        next_phase      = phase;
        next_cnt        = cnt;
        next_cmd_sr     = cmd_sr;
        next_out_sr     = out_sr;
        next_pd_pending = pd_pending;
        next_pd_choice  = pd_choice;
        unique case (phase)
            DP_WAIT: begin
                if (link.cmd_line) begin
                    next_phase  = DP_CMD;
                    next_cmd_sr = 7'h01;
                    next_cnt    = 5'h01;
                end
            end
            DP_CMD: begin
                next_cmd_sr = cmd_full[6:0];
                next_cnt    = cnt + 5'h01;
                if (cnt == CMD_LAST) begin
                    next_phase      = DP_DATA;
                    next_cnt        = 5'h00;
                    next_out_sr     = {code, 2'b00};
                    next_pd_pending = ~cmd_full[`CMD_PD_HIGH_POS];
                    next_pd_choice  = cmd_full[`CMD_PD_LOW_POS]
                                    ? PS_FAST_DOWN : PS_FULL_DOWN;
                end
            end
            DP_DATA: begin
                next_out_sr = {out_sr[14:0], 1'b0};
                next_cnt    = cnt + 5'h01;
                if (cnt == CONV_LAST) begin
                    next_pd_pending = 1'b0;
                end
                if (cnt == FRAME_LAST) begin
                    next_phase = DP_WAIT;
                end
            end
            default: begin
                next_phase = DP_WAIT;
            end
        endcase
    end

    always_ff @(posedge link.sclk or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            phase      <= DP_WAIT;
            cnt        <= 5'h00;
            cmd_sr     <= 7'h00;
            out_sr     <= 16'h0000;
            pd_pending <= 1'b0;
            pd_choice  <= PS_FULL_DOWN;
        end else begin
            phase      <= next_phase;
            cnt        <= next_cnt;
            cmd_sr     <= next_cmd_sr;
            out_sr     <= next_out_sr;
            pd_pending <= next_pd_pending;
            pd_choice  <= next_pd_choice;
        end
    end

    // Power state survives chip select; wakes on the start bit
    always_comb begin
        next_power = power_state;
        if (phase == DP_WAIT && link.cmd_line) begin
            next_power = PS_ACTIVE;
        end else if (phase == DP_DATA && cnt == CONV_LAST
                     && pd_pending) begin
            next_power = pd_choice;
        end
        // External reference from fast power-down needs no wait
        next_ready = (next_power == PS_ACTIVE)
                   && (ready_to_conv
                       || (power_state == PS_FAST_DOWN && ext_sync));
    end

    always_ff @(posedge link.sclk or negedge arst_n) begin
        if (!arst_n) begin
            power_state   <= PS_ACTIVE;
            ready_to_conv <= 1'b1;
        end else begin
            power_state   <= next_power;
            ready_to_conv <= next_ready;
        end
    end

    // Result bit changes after each falling edge
    always_comb begin
        next_dout = (phase == DP_DATA) ? out_sr[15] : 1'b0;
    end

    always_ff @(negedge link.sclk or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            link.res_line <= 1'b0;
        end else begin
            link.res_line <= next_dout;
        end
    end
endmodule

`default_nettype wire

// >>> adc_serial_host.sv
// Host end: link master that issues commands and reads results
`timescale 1ns/100ps
`default_nettype none
`include "adc_link_cfg.svh"

module adc_serial_host #(
    parameter int WAKE_CYCLES = `WAKE_TIME_US * (`CLK_KHZ / 1000),
    parameter bit WORD16      = 1'b0,
    parameter int BUF_DEPTH   = 2
) (
    input  wire logic        clk,         // System clock, 25 MHz
    input  wire logic        arst_n,      // Async reset, low
    adc_link_if.host         link,        // Serial pins
    input  wire logic [7:0]  cmd_byte,    // Command to send
    input  wire logic        cmd_valid,   // Command offered
    output logic             cmd_ready,   // Command taken
    input  wire logic        int_ref,     // Internal reference in use
    output logic [13:0]      res_code,    // Result code
    output logic             res_settled, // Reference had settled
    output logic             res_valid,   // Result offered
    input  wire logic        res_ready,   // User takes result
    output logic             busy         // Transaction running
);
    import adc_link_pkg::*;

    // Half serial period, rounded up so the clock never exceeds max
    localparam int HALF = (`CLK_KHZ + 2 * `SCLK_MAX_KHZ - 1)
                        / (2 * `SCLK_MAX_KHZ);
    localparam logic [7:0]  HALF_LAST  = 8'(HALF - 1);
    localparam logic [4:0]  RISE_TOTAL = 5'(`CMD_BITS + `FRAME_BITS);
    localparam logic [4:0]  RISE_BYTE1 = 5'(`CMD_BITS + `BYTE_BITS);
    localparam logic [7:0]  GAP_LAST   = 8'(`BYTE_GAP_CYCLES - 1);
    localparam logic [19:0] WAKE_LOAD  = 20'(WAKE_CYCLES);
    localparam logic [7:0]  START_MASK = 8'h80;

    host_state_type state;
    host_state_type next_state;
    logic [7:0]     div;
    logic [7:0]     next_div;
    logic           sclk_q;
    logic           next_sclk;
    logic           cs_n_q;
    logic           next_cs_n;
    logic [7:0]     tx_sr;
    logic [7:0]     next_tx_sr;
    logic [15:0]    rx_sr;
    logic [15:0]    next_rx_sr;
    logic [4:0]     rises;
    logic [4:0]     next_rises;
    logic [7:0]     gap;
    logic [7:0]     next_gap;
    logic           tick;
    logic           take_cmd;

    logic           asleep;
    logic           next_asleep;
    logic [19:0]    settle;
    logic [19:0]    next_settle;

    logic           miso_meta;
    logic           miso_sync;

    logic           buf_in_ready;
    logic           buf_in_valid;
    logic [14:0]    buf_in_data;
    logic [14:0]    buf_out_data;

    // Pins come straight from flip-flops
    assign link.sclk     = sclk_q;
    assign link.cs_n     = cs_n_q;
    assign link.cmd_line = tx_sr[7];

    // A command is taken only with room for its result
    assign cmd_ready = (state == HS_IDLE) && buf_in_ready;
    assign take_cmd  = cmd_valid && cmd_ready;
    assign busy      = state != HS_IDLE;
    assign tick      = div == HALF_LAST;

    // Result line crosses from the link side by two flops
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            miso_meta <= 1'b0;
            miso_sync <= 1'b0;
        end else begin
            miso_meta <= link.res_level;
            miso_sync <= miso_meta;
        end
    end

    // Transaction sequencing and serial clock divider
    always_comb begin
        next_state = state;
        next_div   = div;
        next_sclk  = sclk_q;
        next_cs_n  = cs_n_q;
        next_tx_sr = tx_sr;
        next_rx_sr = rx_sr;
        next_rises = rises;
        next_gap   = gap;
        unique case (state)
            HS_IDLE: begin
                next_sclk = 1'b0;
                if (take_cmd) begin
                    next_state = HS_XFER;
                    next_cs_n  = 1'b0;
                    next_div   = 8'h00;
                    next_rises = 5'h00;
                    // Leading bit forced high to mark the command
                    next_tx_sr = cmd_byte | START_MASK;
                end
            end
            HS_XFER: begin
                next_div = tick ? 8'h00 : div + 8'h01;
                if (tick && !sclk_q) begin
                    // Rising edge: take the settled result bit
                    next_sclk  = 1'b1;
                    next_rx_sr = {rx_sr[14:0], miso_sync};
                    next_rises = rises + 5'h01;
                end else if (tick) begin
                    // Falling edge: present the next command bit
                    next_sclk  = 1'b0;
                    next_tx_sr = {tx_sr[6:0], 1'b0};
                    if (rises == RISE_TOTAL) begin
                        next_state = HS_DONE;
                    end else if (!WORD16 && rises == RISE_BYTE1) begin
                        // Close the first byte read, clock held low
                        next_state = HS_GAP;
                        next_gap   = 8'h00;
                    end
                end
            end
            HS_GAP: begin
                next_gap = gap + 8'h01;
                if (gap == GAP_LAST) begin
                    next_state = HS_XFER;
                    next_div   = 8'h00;
                end
            end
            HS_DONE: begin
                next_cs_n  = 1'b1;
                next_state = HS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state  <= HS_IDLE;
            div    <= 8'h00;
            sclk_q <= 1'b0;
            cs_n_q <= 1'b1;
            tx_sr  <= 8'h00;
            rx_sr  <= 16'h0000;
            rises  <= 5'h00;
            gap    <= 8'h00;
        end else begin
            state  <= next_state;
            div    <= next_div;
            sclk_q <= next_sclk;
            cs_n_q <= next_cs_n;
            tx_sr  <= next_tx_sr;
            rx_sr  <= next_rx_sr;
            rises  <= next_rises;
            gap    <= next_gap;
        end
    end

    // Track device sleep and the reference settling wait
    always_comb begin
        next_asleep = asleep;
        next_settle = settle;
        if (settle != 20'h00000) begin
            next_settle = settle - 20'h00001;
        end
        if (take_cmd) begin
            // Device powers down after this conversion if bits ask
            next_asleep = ~cmd_byte[`CMD_PD_HIGH_POS];
            // Start bit wakes it; internal reference needs time
            if (asleep && int_ref) begin
                next_settle = WAKE_LOAD;
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            asleep <= 1'b0;
            settle <= 20'h00000;
        end else begin
            asleep <= next_asleep;
            settle <= next_settle;
        end
    end

    // Of the last 16 received bits, the first 14 are the result, last two dropped
    assign buf_in_valid = state == HS_DONE;
    assign buf_in_data  = {settle == 20'h00000,
                           rx_sr[15:2]};

    // Two-entry buffer absorbs a stalled reader
    adc_word_buffer #(
        .WIDTH (15),
        .DEPTH (BUF_DEPTH)
    ) u_result_buffer (
        .clk       (clk),
        .arst_n    (arst_n),
        .in_data   (buf_in_data),
        .in_valid  (buf_in_valid),
        .in_ready  (buf_in_ready),
        .out_data  (buf_out_data),
        .out_valid (res_valid),
        .out_ready (res_ready)
    );

    assign res_code    = buf_out_data[13:0];
    assign res_settled = buf_out_data[14];
endmodule

`default_nettype wire

// >>> adc_result_serial_readout_properties.sv
// Concurrent checks on the host-to-converter serial link wires
`timescale 1ns/100ps
`default_nettype none

module adc_result_serial_readout_properties (
    input wire logic clk,       // System clock
    input wire logic arst_n,    // Async reset, low
    input wire logic sclk,      // Serial clock
    input wire logic cs_n,      // Chip select, low
    input wire logic cmd_line,  // Command bit
    input wire logic res_line,  // Result bit
    input wire logic res_oe,    // Result drive enable
    input wire logic res_level  // Resolved result line
);
    logic       sclk_q; // Serial clock one cycle ago
    logic [4:0] n_rise; // Serial clock rises in this frame

    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    // Rise counter, cleared while deselected so an abort restarts it
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sclk_q <= 1'b0;
            n_rise <= 5'h00;
        end else begin
            sclk_q <= sclk;
            if (cs_n)
                n_rise <= 5'h00;
            else if (sclk && !sclk_q)
                n_rise <= n_rise + 5'h01;
        end
    end

    // Half periods of the divided clock: 6 system cycles high, at least 6 low
    sequence s_high_half;
        sclk [*6] ##1 !sclk;
    endsequence
    sequence s_low_half;
        !sclk [*6];
    endsequence

    a_idle_clock_low: assert property (cs_n |-> !sclk)
        else $error("serial clock high while deselected");
    a_high_half_width: assert property ($rose(sclk) |-> s_high_half)
        else $error("serial clock high phase not 6 cycles");
    a_low_half_width: assert property ($fell(sclk) |-> s_low_half)
        else $error("serial clock low phase too short");
    a_result_holds_high: assert property (
        sclk && $past(sclk) |-> $stable(res_line))
        else $error("result bit moved while clock high");
    a_cmd_holds_high: assert property (
        sclk && $past(sclk) |-> $stable(cmd_line))
        else $error("command bit moved while clock high");
    a_start_bit_lead: assert property ($fell(cs_n) |-> cmd_line)
        else $error("frame does not open with a high bit");
    a_oe_tracks_select: assert property (res_oe == !cs_n)
        else $error("result drive enable differs from select");
    a_line_released: assert property (
        cs_n |-> !res_level && !res_line)
        else $error("result line not released when deselected");
    a_frame_rise_count: assert property (
        $rose(cs_n) |-> n_rise == 5'h18)
        else $error("frame did not hold 24 clock rises");
endmodule

`default_nettype wire

// >>> test_adc_result_serial_readout.sv
// Self-checking bench for both ends of the serial read-out link
`timescale 1ns/100ps
`default_nettype none

module test_adc_result_serial_readout;
    import adc_link_pkg::*;

    // Wake wait longer than one frame, shorter than two
    localparam int WAKE = 400;

    logic            clk;           // System clock
    logic            arst_n;        // Async reset, low
    logic [7:0]      cmd_byte;      // Command to host
    logic            cmd_valid;     // Command offered
    logic            cmd_ready;     // Host takes command
    logic            int_ref;       // Internal reference
    logic            ext_ref;       // External reference
    logic [13:0]     sample_code;   // Converter sample
    logic [13:0]     res_code;      // Result from host
    logic            res_settled;   // Reference had settled
    logic            res_valid;     // Result offered
    logic            res_ready;     // Bench takes result
    logic            busy;          // Host busy
    power_state_type power_state;   // Device power state
    logic            ready_to_conv; // No wake wait due
    logic [13:0]     w_res_code;    // Result from word host
    logic            w_res_settled; // Word host settle flag
    logic            w_res_valid;   // Word result offered
    logic [23:0]     cmd_seen;      // Command line history
    logic [23:0]     res_seen;      // Result line history
    int              n_fail;        // Mismatches
    int              n_checks;      // Comparisons

    adc_link_if adc_link_if_inst ();

    adc_serial_host #(.WAKE_CYCLES(WAKE), .WORD16(1'b0)) adc_serial_host_inst (
        .clk(clk), .arst_n(arst_n), .link(adc_link_if_inst.host),
        .cmd_byte(cmd_byte), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
        .int_ref(int_ref), .res_code(res_code), .res_settled(res_settled),
        .res_valid(res_valid), .res_ready(res_ready), .busy(busy));

    adc_serial_device adc_serial_device_inst (
        .link(adc_link_if_inst.dev), .arst_n(arst_n),
        .sample_code(sample_code), .ext_ref(ext_ref),
        .power_state(power_state), .ready_to_conv(ready_to_conv));

    adc_result_serial_readout_properties
        adc_result_serial_readout_properties_inst (
        .clk(clk), .arst_n(arst_n), .sclk(adc_link_if_inst.sclk),
        .cs_n(adc_link_if_inst.cs_n), .cmd_line(adc_link_if_inst.cmd_line),
        .res_line(adc_link_if_inst.res_line),
        .res_oe(adc_link_if_inst.res_oe),
        .res_level(adc_link_if_inst.res_level));

    // Word-read pair runs beside the byte-read pair on the same commands
    adc_link_if adc_link_if_w16_inst ();

    adc_serial_host #(.WAKE_CYCLES(WAKE), .WORD16(1'b1))
        adc_serial_host_w16_inst (
        .clk(clk), .arst_n(arst_n), .link(adc_link_if_w16_inst.host),
        .cmd_byte(cmd_byte), .cmd_valid(cmd_valid), .cmd_ready(),
        .int_ref(int_ref), .res_code(w_res_code),
        .res_settled(w_res_settled), .res_valid(w_res_valid),
        .res_ready(res_ready), .busy());

    adc_serial_device adc_serial_device_w16_inst (
        .link(adc_link_if_w16_inst.dev), .arst_n(arst_n),
        .sample_code(sample_code), .ext_ref(ext_ref),
        .power_state(), .ready_to_conv());

    // Wire view: bits as a rising-edge sampler sees them
    always @(posedge adc_link_if_inst.sclk) begin
        cmd_seen <= {cmd_seen[22:0], adc_link_if_inst.cmd_line};
        res_seen <= {res_seen[22:0], adc_link_if_inst.res_level};
    end

    // Free-running system clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Level test at the falling edge, so the result never races an update
    task automatic await(ref logic sig, input logic lvl);
        int i;
        for (i = 0; i < 2000; i++) begin
            @(negedge clk);
            if (sig === lvl)
                return;
        end
        n_fail++;
        complete_run();
    endtask

    // Command handshake, held until the edge that takes it
    task automatic send_cmd(input logic [7:0] c);
        @(posedge clk);
        cmd_byte  <= c;
        cmd_valid <= 1'b1;
        await(cmd_ready, 1'b1);
        @(posedge clk);
        cmd_valid <= 1'b0;
    endtask

    task automatic read_res(input logic [13:0] exp, input logic st);
        await(res_valid, 1'b1);
        check(res_code, exp);
        check(res_settled, st);
        // Word host finishes first, so its result already stands here
        check({w_res_valid, w_res_settled, w_res_code},
              {1'b1, st, exp});
        @(posedge clk);
        res_ready <= 1'b1;
        @(posedge clk);
        res_ready <= 1'b0;
    endtask

    // One conversion: expected code from the coding mode bit
    task automatic run(input logic [7:0] c, input logic [13:0] code,
                       input logic er, input logic [1:0] ps,
                       input logic st);
        logic [13:0] exp;
        exp = c[3] ? code : code ^ 14'h2000;
        @(posedge clk);
        sample_code <= code;
        ext_ref     <= er;
        int_ref     <= ~er;
        send_cmd(c);
        read_res(exp, st);
        check(cmd_seen[23:16], c | 8'h80);
        check(res_seen[15:0], {exp, 2'b00});
        check(power_state, ps);
    endtask

    initial begin
        arst_n      = 1'b0;
        cmd_byte    = 8'h00;
        cmd_valid   = 1'b0;
        int_ref     = 1'b0;
        ext_ref     = 1'b0;
        sample_code = 14'h0000;
        res_ready   = 1'b0;
        n_fail      = 0;
        n_checks    = 0;
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        run(8'h8a, 14'h3fff, 1'b0, PS_ACTIVE, 1'b1);
        run(8'h82, 14'h0000, 1'b0, PS_ACTIVE, 1'b1);
        run(8'h82, 14'h2d3c, 1'b0, PS_ACTIVE, 1'b1);
        run(8'h8b, 14'h1a5c, 1'b0, PS_ACTIVE, 1'b1);
        run(8'h89, 14'h0f0f, 1'b1, PS_FAST_DOWN, 1'b1);
        run(8'h0a, 14'h1234, 1'b1, PS_ACTIVE, 1'b1);
        check(ready_to_conv, 1'b1);
        run(8'h88, 14'h2222, 1'b0, PS_FULL_DOWN, 1'b1);
        run(8'h8a, 14'h0001, 1'b0, PS_ACTIVE, 1'b0);
        check(ready_to_conv, 1'b0);
        run(8'h8a, 14'h3ffe, 1'b0, PS_ACTIVE, 1'b1);
        // Reader stalls: two results parked, then the host refuses more
        send_cmd(8'h8a);
        send_cmd(8'h8a);
        await(busy, 1'b0);
        check(cmd_ready, 1'b0);
        read_res(14'h3ffe, 1'b1);
        read_res(14'h3ffe, 1'b1);
        @(negedge clk);
        check(res_valid, 1'b0);
        complete_run();
    end
endmodule

`default_nettype wire
